// file: twmt_master.sv
`timescale 1ns/1ps
module twmt_master
  import twmt_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rd_data,
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic            irq
);

  twmt_regs_t r;
  twmt_regs_t next_r;
  logic [1:0] lines_s;
  logic       scl_s;
  logic       sda_s;
  logic       tick;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  twmt_sync u_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .in_raw   ({scl_in, sda_in}),
    .out_sync (lines_s)
  );

  assign scl_s = lines_s[1];
  assign sda_s = lines_s[0];
  assign tick  = (r.tmr == 8'h00);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic       hw_set;
    logic [7:0] rd_val;
    hw_set = 1'b0;
    rd_val = 8'h00;
    next_r = r;
    next_r.rdata    = 8'h00;
    next_r.sda_prev = sda_s;
    next_r.tmr      = tick ? QUARTER_CYC - 8'h01 : r.tmr - 8'h01;
    next_r.ph       = tick ? r.ph + 2'h1 : r.ph;

    // bus busy from observed start and stop conditions
    if (scl_s && r.sda_prev && !sda_s) begin
      next_r.busy = 1'b1;
    end else if (scl_s && !r.sda_prev && sda_s) begin
      next_r.busy = 1'b0;
    end

    if (wr_en) begin
      if (addr == REG_CTRL) begin
        if (wdata[CB_FLAG]) begin
          next_r.ctrl[CB_FLAG] = 1'b0;
        end
        next_r.ctrl[CB_ACKEN] = wdata[CB_ACKEN];
        next_r.ctrl[CB_START] = wdata[CB_START];
        next_r.ctrl[CB_STOP]  = wdata[CB_STOP];
        next_r.ctrl[CB_EN]    = wdata[CB_EN];
        next_r.ctrl[CB_IE]    = wdata[CB_IE];
      end else if (addr == REG_DATA) begin
        if (r.ctrl[CB_FLAG]) begin
          next_r.data        = wdata;
          next_r.ctrl[CB_WC] = 1'b0;
        end else begin
          next_r.ctrl[CB_WC] = 1'b1;
        end
      end else if (addr == REG_STATUS) begin
        next_r.presc = wdata[1:0];
      end else if (addr == REG_ROLE) begin
        next_r.roles = wdata[3:0];
      end
    end

    if (rd_en) begin
      if (addr == REG_CTRL) begin
        rd_val = r.ctrl;
      end else if (addr == REG_DATA) begin
        rd_val = r.data;
      end else if (addr == REG_STATUS) begin
        rd_val = (r.code & 8'hF8) | {6'h00, r.presc};
      end else if (addr == REG_ROLE) begin
        rd_val = {2'h0, r.role, r.roles};
      end
      next_r.rdata = rd_val;
    end

    case (r.state)
      ST_IDLE: begin
        next_r.scl_low = 1'b0;
        next_r.sda_low = 1'b0;
        next_r.role    = ROLE_NONE;
        if (r.ctrl[CB_EN] && r.ctrl[CB_START] && !r.ctrl[CB_FLAG]
            && (r.roles[RB_MT] || r.roles[RB_MR])) begin
          next_r.state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // only a quiet bus with both lines high may take a start
        if (!r.busy && scl_s && sda_s) begin
          next_r.state = ST_START;
        end
      end
      ST_START: begin
        if (tick) begin
          if (r.ph == 2'h0) begin
            next_r.sda_low = 1'b1;
          end else if (r.ph == 2'h1) begin
            next_r.scl_low = 1'b1;
          end else begin
            hw_set         = 1'b1;
            next_r.code    = CODE_START;
            next_r.is_addr = 1'b1;
            next_r.state   = ST_HOLD;
          end
        end
      end
      ST_HOLD: begin
        next_r.scl_low = !r.lost;
        if (!r.ctrl[CB_FLAG]) begin
          if (r.lost) begin
            next_r.lost    = 1'b0;
            next_r.scl_low = 1'b0;
            next_r.state   = r.ctrl[CB_START] ? ST_WAIT : ST_IDLE;
          end else if (r.ctrl[CB_STOP]) begin
            next_r.state = ST_STOP;
          end else if (r.ctrl[CB_START]) begin
            next_r.state = ST_RSTART;
          end else begin
            next_r.shreg = r.data;
            next_r.bitn  = 4'h0;
            next_r.state = ST_BYTE;
            if (r.is_addr) begin
              next_r.role = r.data[0] ? ROLE_MR : ROLE_MT;
            end
          end
        end
      end
      ST_BYTE: begin
        if (tick) begin
          if (r.ph == 2'h0) begin
            next_r.sda_low = (r.bitn != ACK_BIT) && !r.shreg[7];
          end else if (r.ph == 2'h1) begin
            next_r.scl_low = 1'b0;
          end else if (r.ph == 2'h2) begin
            if (r.bitn == ACK_BIT) begin
              next_r.acked = !sda_s;
            end else if (!r.sda_low && !sda_s) begin
              // another master pulled data low: back off at once
              hw_set         = 1'b1;
              next_r.lost    = 1'b1;
              next_r.scl_low = 1'b0;
              next_r.sda_low = 1'b0;
              next_r.code    = CODE_ARB_LOST;
              next_r.role    = ROLE_NONE;
              next_r.is_addr = 1'b0;
              next_r.state   = ST_HOLD;
            end
          end else begin
            next_r.scl_low = 1'b1;
            if (r.bitn == ACK_BIT) begin
              hw_set         = 1'b1;
              next_r.code    = twmt_done_code(r.is_addr, r.acked);
              next_r.is_addr = 1'b0;
              next_r.state   = ST_HOLD;
            end else begin
              next_r.shreg = {r.shreg[6:0], 1'b1};
              next_r.bitn  = r.bitn + 4'h1;
            end
          end
        end
      end
      ST_RSTART: begin
        if (tick) begin
          if (r.ph == 2'h0) begin
            next_r.sda_low = 1'b0;
          end else if (r.ph == 2'h1) begin
            next_r.scl_low = 1'b0;
          end else if (r.ph == 2'h2) begin
            next_r.sda_low = 1'b1;
          end else begin
            // clock pulled low again so no other master can take over
            next_r.scl_low = 1'b1;
            hw_set         = 1'b1;
            next_r.code    = CODE_RSTART;
            next_r.is_addr = 1'b1;
            next_r.state   = ST_HOLD;
          end
        end
      end
      ST_STOP: begin
        if (tick) begin
          if (r.ph == 2'h0) begin
            next_r.sda_low = 1'b1;
          end else if (r.ph == 2'h1) begin
            next_r.scl_low = 1'b0;
          end else begin
            next_r.sda_low       = 1'b0;
            next_r.ctrl[CB_STOP] = 1'b0;
            next_r.role          = ROLE_NONE;
            next_r.state         = r.ctrl[CB_START] ? ST_WAIT : ST_IDLE;
          end
        end
      end
      default: begin
        next_r.state = ST_IDLE;
      end
    endcase

    // waiting states keep the phase timer primed for the next step
    if (next_r.state == ST_IDLE || next_r.state == ST_WAIT || next_r.state == ST_HOLD) begin
      next_r.ph  = 2'h0;
      next_r.tmr = QUARTER_CYC - 8'h01;
    end

    if (!r.ctrl[CB_EN]) begin
      next_r.state   = ST_IDLE;
      next_r.scl_low = 1'b0;
      next_r.sda_low = 1'b0;
      next_r.lost    = 1'b0;
    end

    // hardware set beats a software clear in the same cycle
    if (hw_set) begin
      next_r.ctrl[CB_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r          <= '0;
      r.state    <= ST_IDLE;
      r.ctrl     <= CTRL_RESET;
      r.data     <= DATA_RESET;
      r.code     <= CODE_RESET;
      r.roles    <= ROLES_RESET;
      r.tmr      <= QUARTER_CYC - 8'h01;
      r.sda_prev <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign rd_data = r.rdata;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe  = r.scl_low;
  assign sda_oe  = r.sda_low;
  assign irq     = r.ctrl[CB_IE] && r.ctrl[CB_FLAG];

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence seq_start_done;
    r.state == ST_START && r.ph == 2'h2 && tick;
  endsequence

  sequence seq_rstart_done;
    r.state == ST_RSTART && r.ph == 2'h3 && tick;
  endsequence

  sequence seq_byte_done;
    r.state == ST_BYTE && r.ph == 2'h3 && tick && r.bitn == ACK_BIT && r.ctrl[CB_EN];
  endsequence

  sequence seq_stop_done;
    r.state == ST_STOP && r.ph == 2'h2 && tick && r.ctrl[CB_EN];
  endsequence

  chk_start_code: assert property (seq_start_done and r.ctrl[CB_EN] |=>
    r.ctrl[CB_FLAG] && r.code == CODE_START && r.scl_low && r.sda_low)
    else $error("start did not report 0x08 with flag set");

  chk_rstart_own: assert property (seq_rstart_done and r.ctrl[CB_EN] |=>
    r.ctrl[CB_FLAG] && r.code == CODE_RSTART && r.state == ST_HOLD && r.scl_low)
    else $error("repeated start did not report 0x10 or lost the clock");

  chk_addr_code: assert property (seq_byte_done and r.is_addr |=>
    r.ctrl[CB_FLAG] && r.code == ($past(r.acked) ? CODE_ADDR_ACK : CODE_ADDR_NACK))
    else $error("address status code wrong");

  chk_data_code: assert property (seq_byte_done and !r.is_addr |=>
    r.ctrl[CB_FLAG] && r.code == ($past(r.acked) ? CODE_DATA_ACK : CODE_DATA_NACK))
    else $error("data status code wrong");

  chk_role_pick: assert property (r.state == ST_HOLD && !r.ctrl[CB_FLAG] && r.ctrl[CB_EN]
    && !r.lost && !r.ctrl[CB_STOP] && !r.ctrl[CB_START] && r.is_addr |=>
    r.state == ST_BYTE && r.role == ($past(r.data[0]) ? ROLE_MR : ROLE_MT))
    else $error("role not taken from address direction bit");

  chk_wc_set: assert property (wr_en && addr == REG_DATA && !r.ctrl[CB_FLAG] |=>
    r.ctrl[CB_WC] && $stable(r.data))
    else $error("data write while flag low was not refused");

  chk_stop_quiet: assert property (seq_stop_done |=>
    !r.ctrl[CB_STOP] && !r.sda_low && !r.scl_low && !$rose(r.ctrl[CB_FLAG]))
    else $error("stop left request set or raised the flag");

  chk_suspend: assert property (r.ctrl[CB_FLAG] |->
    !(r.state inside {ST_START, ST_BYTE, ST_RSTART, ST_STOP}))
    else $error("bus activity while flag set");

  chk_hold_scl: assert property (r.ctrl[CB_FLAG] && r.state == ST_HOLD && !r.lost |->
    r.scl_low)
    else $error("clock released while flag set");

  chk_arb_lost: assert property (r.state == ST_BYTE && r.ph == 2'h2 && tick && r.ctrl[CB_EN]
    && r.bitn != ACK_BIT && !r.sda_low && !sda_s |=>
    r.code == CODE_ARB_LOST && r.ctrl[CB_FLAG] && !r.scl_low && !r.sda_low)
    else $error("arbitration loss not reported or bus not released");

  chk_wait_free: assert property (r.state == ST_WAIT && r.busy |=> r.state != ST_START)
    else $error("start issued on a busy bus");

  chk_irq_level: assert property (r.ctrl[CB_IE] && $rose(r.ctrl[CB_FLAG]) |->
    irq ##1 (irq || !r.ctrl[CB_FLAG]))
    else $error("interrupt request does not follow flag");

endmodule : twmt_master

// file: twmt_pkg.sv
package twmt_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_DATA     = 8'h01;
  localparam logic [7:0] REG_STATUS   = 8'h02;
  localparam logic [7:0] REG_ROLE     = 8'h03;

  localparam int CB_FLAG  = 7;
  localparam int CB_ACKEN = 6;
  localparam int CB_START = 5;
  localparam int CB_STOP  = 4;
  localparam int CB_WC    = 3;
  localparam int CB_EN    = 2;
  localparam int CB_IE    = 0;

  localparam int RB_MT    = 0;
  localparam int RB_MR    = 1;
  localparam int RB_ST    = 2;
  localparam int RB_SR    = 3;

  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] DATA_RESET   = 8'hFF;
  localparam logic [7:0] CODE_RESET   = 8'hF8;
  localparam logic [3:0] ROLES_RESET  = 4'hF;

  localparam logic [1:0] ROLE_NONE    = 2'h0;
  localparam logic [1:0] ROLE_MT      = 2'h1;
  localparam logic [1:0] ROLE_MR      = 2'h2;

  // ------------------------------------------------------------
  // status codes
  // ------------------------------------------------------------
  localparam logic [7:0] CODE_START     = 8'h08;
  localparam logic [7:0] CODE_RSTART    = 8'h10;
  localparam logic [7:0] CODE_ADDR_ACK  = 8'h18;
  localparam logic [7:0] CODE_ADDR_NACK = 8'h20;
  localparam logic [7:0] CODE_DATA_ACK  = 8'h28;
  localparam logic [7:0] CODE_DATA_NACK = 8'h30;
  localparam logic [7:0] CODE_ARB_LOST  = 8'h38;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int BIT_PERIOD_NS = 10000;
  localparam logic [7:0] QUARTER_CYC = 8'(BIT_PERIOD_NS / 4 / CLK_PERIOD_NS);
  localparam logic [3:0] ACK_BIT     = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_WAIT   = 3'b001,
    ST_START  = 3'b010,
    ST_HOLD   = 3'b011,
    ST_BYTE   = 3'b100,
    ST_RSTART = 3'b101,
    ST_STOP   = 3'b110
  } twmt_state_t;

  typedef struct packed {
    twmt_state_t state;
    logic [7:0]  ctrl;
    logic [7:0]  data;
    logic [7:0]  code;
    logic [1:0]  presc;
    logic [3:0]  roles;
    logic [1:0]  role;
    logic [7:0]  tmr;
    logic [1:0]  ph;
    logic [3:0]  bitn;
    logic [7:0]  shreg;
    logic        is_addr;
    logic        acked;
    logic        lost;
    logic        scl_low;
    logic        sda_low;
    logic        busy;
    logic        sda_prev;
    logic [7:0]  rdata;
  } twmt_regs_t;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
  } twmt_sync_regs_t;

  function automatic logic [7:0] twmt_done_code(input logic is_addr, input logic acked);
    if (is_addr) begin
      twmt_done_code = acked ? CODE_ADDR_ACK : CODE_ADDR_NACK;
    end else begin
      twmt_done_code = acked ? CODE_DATA_ACK : CODE_DATA_NACK;
    end
  endfunction : twmt_done_code

endpackage : twmt_pkg

// file: twmt_sync.sv
`timescale 1ns/1ps
module twmt_sync
  import twmt_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [1:0] in_raw,
  output logic      [1:0] out_sync
);

  twmt_sync_regs_t r;
  twmt_sync_regs_t next_r;

  // first stage feeds only the second; lines idle high
  always_comb begin
    next_r    = r;
    next_r.s1 = in_raw;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r <= '{s1: 2'h3, s2: 2'h3};
    end else begin
      r <= next_r;
    end
  end

  assign out_sync = r.s2;

endmodule : twmt_sync

// file: twmt_slave_model.sv
`timescale 1ns/1ps
module twmt_slave_model (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       ack_on,
  input  wire logic       lose_arb,
  output logic            sda_pull,
  output logic [7:0]      last_byte,
  output logic [7:0]      byte_cnt
);
  logic [3:0] bitn     = 4'h0;
  logic [7:0] shreg    = 8'h00;
  logic       ack_pull = 1'b0;
  logic       arb_pull = 1'b0;

  initial begin
    last_byte = 8'h00;
    byte_cnt  = 8'h00;
  end

  assign sda_pull = ack_pull | arb_pull;

  // start, repeated start and stop all restart the count
  always @(sda) begin
    if (scl) begin
      bitn     = 4'h0;
      ack_pull = 1'b0;
    end
  end

  always @(posedge scl) begin
    if (bitn < 4'h8) begin
      shreg = {shreg[6:0], sda};
    end
    bitn = bitn + 4'h1;
  end

  always @(negedge scl) begin
    if (bitn == 4'h8 && ack_on) begin
      ack_pull = 1'b1;
    end else if (bitn == 4'h9) begin
      ack_pull  = 1'b0;
      bitn      = 4'h0;
      last_byte = shreg;
      byte_cnt  = byte_cnt + 8'h01;
    end else if (bitn == 4'h0 && lose_arb) begin
      // a rival master sending 0; its release looks like a stop
      arb_pull = 1'b1;
      #20000;
      arb_pull = 1'b0;
    end
  end
endmodule : twmt_slave_model

// file: tb.sv
`timescale 1ns/1ps
module tb
  import twmt_pkg::*;
;
  logic       clk_sys = 1'b0;
  logic       rst     = 1'b1;
  logic [7:0] addr    = 8'h00;
  logic [7:0] wdata   = 8'h00;
  logic       wr_en   = 1'b0;
  logic       rd_en   = 1'b0;
  logic [7:0] rd_data;
  logic       scl_oe;
  logic       sda_oe;
  logic       scl_out;
  logic       sda_out;
  logic       irq;
  logic       sda_pull;
  logic       ack_on   = 1'b1;
  logic       lose_arb = 1'b0;
  logic [7:0] last_byte;
  logic [7:0] byte_cnt;
  logic [7:0] rv;
  logic       scl_w;
  logic       sda_w;
  int         fails        = 0;
  int         total_checks = 0;

  // ------------------------------------------------
  // open-drain lines with pull-ups
  // ------------------------------------------------
  assign scl_w = !scl_oe;
  assign sda_w = !(sda_oe | sda_pull);

  initial begin
    forever #25 clk_sys = !clk_sys;
  end

  twmt_master twmt_master_i (
    .clk_sys (clk_sys),
    .rst     (rst),
    .addr    (addr),
    .wdata   (wdata),
    .wr_en   (wr_en),
    .rd_en   (rd_en),
    .rd_data (rd_data),
    .scl_in  (scl_w),
    .scl_out (scl_out),
    .scl_oe  (scl_oe),
    .sda_in  (sda_w),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .irq     (irq)
  );

  twmt_slave_model twmt_slave_model_i (
    .scl       (scl_w),
    .sda       (sda_w),
    .ack_on    (ack_on),
    .lose_arb  (lose_arb),
    .sda_pull  (sda_pull),
    .last_byte (last_byte),
    .byte_cnt  (byte_cnt)
  );

  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task automatic give_verdict();
    if (fails == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    rv = rd_data;
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                        input string name);
    rd(a);
    chk(name, e, rv & m);
  endtask : rd_chk

  // polls the flag; a byte takes 1800 cycles, so 3000 polls is ample
  task automatic wait_flag();
    rv = 8'h00;
    for (int i = 0; i < 3000 && rv[7] !== 1'b1; i++) begin
      rd(REG_CTRL);
    end
    if (rv[7] !== 1'b1) begin
      fails++;
      $display("[ERR] flag wait expected 1 seen 0");
      give_verdict();
    end
  endtask : wait_flag

  task automatic send(input logic [7:0] d, input logic a, input logic [7:0] code);
    ack_on <= a;
    wr(REG_DATA, d);
    wr(REG_CTRL, 8'h85);
    wait_flag();
    rd_chk(REG_STATUS, 8'hF8, code, "status");
    chk("slave_byte", d, last_byte);
  endtask : send

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk(REG_CTRL, 8'hFF, 8'h00, "ctrl_reset");
    rd_chk(REG_DATA, 8'hFF, 8'hFF, "data_reset");
    rd_chk(REG_STATUS, 8'hFF, 8'hF8, "status_reset");
    rd_chk(REG_ROLE, 8'hFF, 8'h0F, "role_reset");
    rd_chk(8'h07, 8'hFF, 8'h00, "unmapped");
    wr(REG_DATA, 8'h33);
    rd_chk(REG_CTRL, 8'h08, 8'h08, "write_collision");
    rd_chk(REG_DATA, 8'hFF, 8'hFF, "data_kept");
    wr(REG_STATUS, 8'h03);
    rd_chk(REG_STATUS, 8'hFF, 8'hFB, "prescaler");
    // no master role permitted: the start must wait
    wr(REG_ROLE, 8'h00);
    wr(REG_CTRL, 8'hA5);
    repeat (300) @(posedge clk_sys);
    rd_chk(REG_CTRL, 8'h80, 8'h00, "no_start");
    chk("sda_idle", 8'h00, {7'h0, sda_oe});
    wr(REG_ROLE, 8'h0F);
    wait_flag();
    rd_chk(REG_STATUS, 8'hF8, 8'h08, "start_code");
    chk("irq_on", 8'h01, {7'h0, irq});
    // look between edges so the registered pins have settled
    repeat (200) @(negedge clk_sys);
    chk("scl_held", 8'h01, {7'h0, scl_oe});
    chk("pin_drive", 8'h00, {6'h00, scl_out, sda_out});
    chk("no_bytes", 8'h00, byte_cnt);
    send(8'hA0, 1'b1, 8'h18);
    rd_chk(REG_ROLE, 8'hFF, 8'h1F, "role_mt");
    send(8'h5A, 1'b1, 8'h28);
    send(8'hC3, 1'b0, 8'h30);
    wr(REG_CTRL, 8'hA4);
    wait_flag();
    rd_chk(REG_STATUS, 8'hF8, 8'h10, "rstart_code");
    chk("irq_off", 8'h00, {7'h0, irq});
    chk("bus_owned", 8'h01, {7'h0, scl_oe});
    // read direction bit after the repeated start switches the role
    send(8'h43, 1'b0, 8'h20);
    rd_chk(REG_ROLE, 8'hFF, 8'h2F, "role_mr");
    wr(REG_CTRL, 8'h95);
    repeat (300) @(posedge clk_sys);
    rd_chk(REG_CTRL, 8'hFF, 8'h05, "stop_ctrl");
    chk("scl_free", 8'h01, {7'h0, scl_w});
    chk("sda_free", 8'h01, {7'h0, sda_w});
    // rival master wins the first address bit
    lose_arb <= 1'b1;
    wr(REG_CTRL, 8'hA4);
    wait_flag();
    rd_chk(REG_STATUS, 8'hF8, 8'h08, "start_again");
    lose_arb <= 1'b0;
    ack_on   <= 1'b1;
    wr(REG_DATA, 8'hFF);
    wr(REG_CTRL, 8'h84);
    wait_flag();
    rd_chk(REG_STATUS, 8'hF8, 8'h38, "arb_code");
    chk("arb_scl", 8'h00, {7'h0, scl_oe});
    chk("arb_sda", 8'h00, {7'h0, sda_oe});
    wr(REG_CTRL, 8'h84);
    repeat (600) @(posedge clk_sys);
    rd_chk(REG_CTRL, 8'h80, 8'h00, "arb_idle");
    chk("arb_idle_sda", 8'h00, {7'h0, sda_oe});
    // stop and start in one request: the start waits until its own stop is seen
    wr(REG_CTRL, 8'hA4);
    wait_flag();
    wr(REG_CTRL, 8'hB4);
    wait_flag();
    rd_chk(REG_STATUS, 8'hF8, 8'h08, "stop_start");
    rd_chk(REG_CTRL, 8'h10, 8'h00, "stop_cleared");
    wr(REG_CTRL, 8'h94);
    repeat (300) @(posedge clk_sys);
    rd_chk(REG_CTRL, 8'hB0, 8'h00, "final_stop");
    give_verdict();
  end

  // whole run stays far below this
  initial begin
    repeat (90000) @(posedge clk_sys);
    fails++;
    give_verdict();
  end
endmodule : tb
